// [logic/pwmcs_top.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - reset restores registers except duty, pin goes input
// - control bit 7 enables the module
// - control bit 5 reads output level
// - control bit 4 selects output polarity
// - control bits 6, 3-0 read zero
// - duty high holds duty bits 9-2
// - duty high kept across this reset
// - only ordered bring-up gives full first period
// - 20 MHz, 1:1, 0xff gives 19.53 kHz
// - 8 MHz, 1:1, 0x3f gives 31.25 kHz
// - period wrap clears timer, sets output if duty nonzero, latches duty
// - disabled output stays at idle polarity level
// - time base is timer plus two phase bits
module pwmcs_top #(
   parameter int ROUTE_CODE = 1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic      [1:0]  bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [4:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             pwm_pin_o,
   output logic             pwm_pin_oe
);

   if (ROUTE_CODE < 0 || ROUTE_CODE > 63) begin : g_bad_route
      $error("ROUTE_CODE must fit the 6-bit pin select field");
   end

   typedef struct packed {
      logic       aw_held;
      logic [4:0] aw_addr;
      logic       w_held;
      logic [7:0] w_data;
      logic       w_strb0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic       enable;
      logic       polarity;
      logic [7:0] duty_high;
      logic [1:0] duty_low;
      logic       run;
      logic [1:0] prescale;
      logic [7:0] period;
      logic       match_flag;
      logic       pin_dir;
      logic [5:0] pin_sel;
      logic [9:0] duty_latched;
      logic       active;
      logic       level;
   } pwmcs_state_t;

   pwmcs_state_t s;
   pwmcs_state_t next_s;
   logic         do_write;
   logic [7:0]   rd;
   logic [9:0]   tb;
   logic [7:0]   tmr_count;
   logic [1:0]   tmr_phase;
   logic         tmr_start;

   // aligned word inside the register window
   function automatic logic is_mapped(input logic [4:0] addr);
      return (addr[1:0] == 2'h0) && (addr <= pwmcs_pkg::OFS_PIN);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // shared period timer
   pwmcs_timer u_timer (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .run          (s.run),
      .prescale     (s.prescale),
      .period       (s.period),
      .count        (tmr_count),
      .phase        (tmr_phase),
      .period_start (tmr_start)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic: bus slave, registers, pulse generator, reset
   always_comb begin
      next_s   = s;
      rd       = 8'h00;
      do_write = s.aw_held && s.w_held && !s.bvalid;
      tb       = {tmr_count, tmr_phase};

      // response channels drop once taken
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // write address and data are taken independently
      if (awvalid && !s.aw_held) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && !s.w_held) begin
         next_s.w_held  = 1'b1;
         next_s.w_data  = wdata[7:0];
         next_s.w_strb0 = wstrb[0];
      end

      // register write once both halves are held
      if (do_write) begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = is_mapped(s.aw_addr) ? pwmcs_pkg::RESP_OKAY
                                               : pwmcs_pkg::RESP_SLVERR;
         if (s.w_strb0) begin
            case (s.aw_addr)
               pwmcs_pkg::OFS_CONTROL: begin
                  next_s.enable   = s.w_data[pwmcs_pkg::EN_BIT];
                  next_s.polarity = s.w_data[pwmcs_pkg::POL_BIT];
               end
               pwmcs_pkg::OFS_DUTY_HI: begin
                  next_s.duty_high = s.w_data;
               end
               pwmcs_pkg::OFS_DUTY_LO: begin
                  next_s.duty_low = s.w_data[pwmcs_pkg::DCL_LSB +: 2];
               end
               pwmcs_pkg::OFS_TCTL: begin
                  next_s.run      = s.w_data[pwmcs_pkg::RUN_BIT];
                  next_s.prescale = s.w_data[1:0];
               end
               pwmcs_pkg::OFS_PERIOD: begin
                  next_s.period = s.w_data;
               end
               pwmcs_pkg::OFS_FLAGS: begin
                  next_s.match_flag = s.match_flag & ~s.w_data[pwmcs_pkg::FLAG_BIT];
               end
               pwmcs_pkg::OFS_PIN: begin
                  next_s.pin_dir = s.w_data[pwmcs_pkg::DIR_BIT];
                  next_s.pin_sel = s.w_data[5:0];
               end
               default: begin
                  next_s.enable = next_s.enable;  // unmapped or count: no effect
               end
            endcase
         end
      end

      // read mux
      case (araddr)
         pwmcs_pkg::OFS_CONTROL: begin
            rd[pwmcs_pkg::EN_BIT]  = s.enable;
            rd[pwmcs_pkg::OUT_BIT] = s.level;
            rd[pwmcs_pkg::POL_BIT] = s.polarity;
         end
         pwmcs_pkg::OFS_DUTY_HI: rd = s.duty_high;
         pwmcs_pkg::OFS_DUTY_LO: rd[pwmcs_pkg::DCL_LSB +: 2] = s.duty_low;
         pwmcs_pkg::OFS_TCTL: begin
            rd[pwmcs_pkg::RUN_BIT] = s.run;
            rd[1:0]                = s.prescale;
         end
         pwmcs_pkg::OFS_PERIOD: rd = s.period;
         pwmcs_pkg::OFS_COUNT:  rd = tmr_count;
         pwmcs_pkg::OFS_FLAGS:  rd[pwmcs_pkg::FLAG_BIT] = s.match_flag;
         pwmcs_pkg::OFS_PIN: begin
            rd[pwmcs_pkg::DIR_BIT] = s.pin_dir;
            rd[5:0]                = s.pin_sel;
         end
         default: rd = 8'h00;
      endcase
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = rd;
         next_s.rresp  = is_mapped(araddr) ? pwmcs_pkg::RESP_OKAY
                                           : pwmcs_pkg::RESP_SLVERR;
      end

      // timer match sets the flag; a set beats a same-cycle clear
      next_s.match_flag = next_s.match_flag | tmr_start;

      // period start latches the buffered duty and raises the pulse unless the duty is zero
      if (tmr_start) begin
         next_s.duty_latched = {s.duty_high, s.duty_low};
         next_s.active       = ({s.duty_high, s.duty_low} != 10'h000);
      end else if (s.active && tb == s.duty_latched) begin
         next_s.active = 1'b0;
      end

      // enable gates the pulse at any point, so an early enable cuts a period
      next_s.level = next_s.polarity ^ (next_s.enable & next_s.active);

      // synchronous reset; duty bits keep their value
      if (!aresetn) begin
         next_s              = '0;
         next_s.enable       = pwmcs_pkg::CONTROL_RST[pwmcs_pkg::EN_BIT];
         next_s.polarity     = pwmcs_pkg::CONTROL_RST[pwmcs_pkg::POL_BIT];
         next_s.level        = pwmcs_pkg::CONTROL_RST[pwmcs_pkg::POL_BIT];
         next_s.run          = pwmcs_pkg::RUN_RST;
         next_s.prescale     = pwmcs_pkg::PRESC_RST;
         next_s.period       = pwmcs_pkg::PERIOD_RST;
         next_s.pin_dir      = pwmcs_pkg::PIN_DIR_RST;  // pin to input
         next_s.pin_sel      = pwmcs_pkg::PIN_SEL_RST;
         next_s.duty_high    = s.duty_high;
         next_s.duty_low     = s.duty_low;
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign awready    = !s.aw_held;
   assign wready     = !s.w_held;
   assign bvalid     = s.bvalid;
   assign bresp      = s.bresp;
   assign arready    = !s.rvalid;
   assign rvalid     = s.rvalid;
   assign rresp      = s.rresp;
   assign rdata      = {24'h000000, s.rdata};
   assign pwm_pin_o  = s.level;
   // pin driven only when direction is output and the select routes this module
   assign pwm_pin_oe = !s.pin_dir && (s.pin_sel == 6'(ROUTE_CODE));

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   chk_reset_state: assert property (@(posedge aclk)
      !aresetn |=> (!s.enable && !s.polarity && s.pin_dir && !pwm_pin_oe && !s.run))
      else $error("registers not at reset values after reset");

   chk_enable_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && s.w_strb0 && s.aw_addr == pwmcs_pkg::OFS_CONTROL)
      |=> (s.enable == $past(s.w_data[7]) && s.polarity == $past(s.w_data[4])))
      else $error("control write did not update enable or polarity");

   chk_ctrl_readback: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == pwmcs_pkg::OFS_CONTROL)
      |=> (rvalid && rdata[5] == $past(pwm_pin_o) && rdata[7] == $past(s.enable)))
      else $error("control read does not show output level");

   chk_ctrl_unused: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == pwmcs_pkg::OFS_CONTROL)
      |=> (rdata[6] == 1'b0 && rdata[3:0] == 4'h0))
      else $error("unimplemented control bits read nonzero");

   chk_duty_high: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && s.w_strb0 && s.aw_addr == pwmcs_pkg::OFS_DUTY_HI)
      |=> (s.duty_high == $past(s.w_data)) ##1 (s.duty_high == $past(s.duty_high)
          || $past(do_write)))
      else $error("duty high register did not store written value");

   chk_duty_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      tmr_start |=> (s.duty_latched == $past({s.duty_high, s.duty_low})
                     && s.active == ($past({s.duty_high, s.duty_low}) != 10'h000)
                     && s.match_flag))
      else $error("period start did not latch duty, raise pulse or set flag");

   chk_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (!s.enable || !s.active) |-> (pwm_pin_o == s.polarity))
      else $error("output not at idle level");

   chk_pulse_end: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.active && !tmr_start && tb == s.duty_latched) |=> (!s.active ##1
       (!s.enable || pwm_pin_o == s.polarity || s.active)))
      else $error("pulse did not end when time base reached duty");

   // a disabling write must park the pin at the written polarity at once
   chk_disable_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && s.w_strb0 && s.aw_addr == pwmcs_pkg::OFS_CONTROL
       && !s.w_data[pwmcs_pkg::EN_BIT])
      |=> (pwm_pin_o == $past(s.w_data[pwmcs_pkg::POL_BIT])))
      else $error("output left its idle level after disable");

   chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && s.w_strb0 && s.aw_addr == pwmcs_pkg::OFS_FLAGS
       && s.w_data[pwmcs_pkg::FLAG_BIT] && !tmr_start)
      |=> !s.match_flag)
      else $error("match flag not cleared by software");

   chk_pin_input: assert property (@(posedge aclk) disable iff (!aresetn)
      s.pin_dir |-> !pwm_pin_oe)
      else $error("pin driven while direction is input");

endmodule

// [pkg/pwmcs_pkg.sv]
package pwmcs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses on the axi4-lite port)
   localparam int         ADDR_W       = 5;
   localparam logic [4:0] OFS_CONTROL  = 5'h00;
   localparam logic [4:0] OFS_DUTY_HI  = 5'h04;
   localparam logic [4:0] OFS_DUTY_LO  = 5'h08;
   localparam logic [4:0] OFS_TCTL     = 5'h0c;
   localparam logic [4:0] OFS_PERIOD   = 5'h10;
   localparam logic [4:0] OFS_COUNT    = 5'h14;
   localparam logic [4:0] OFS_FLAGS    = 5'h18;
   localparam logic [4:0] OFS_PIN      = 5'h1c;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int EN_BIT    = 7;
   localparam int OUT_BIT   = 5;
   localparam int POL_BIT   = 4;
   localparam int DCL_LSB   = 6;
   localparam int RUN_BIT   = 7;
   localparam int FLAG_BIT  = 0;
   localparam int DIR_BIT   = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic       RUN_RST      = 1'b0;
   localparam logic [1:0] PRESC_RST    = 2'h0;
   localparam logic [7:0] PERIOD_RST   = 8'hff;
   localparam logic       PIN_DIR_RST  = 1'b1;
   localparam logic [5:0] PIN_SEL_RST  = 6'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // timing and bus answers
   localparam logic [8:0] PHASES       = 9'h004;  // system clocks per timer step at 1:1
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // prescale code 0..3 selects 1, 4, 16, 64: a left shift of twice the code
   function automatic logic [2:0] presc_shift(input logic [1:0] code);
      return {code, 1'b0};
   endfunction

endpackage

// [logic/pwmcs_timer.sv]
`timescale 1ns/1ns
module pwmcs_timer (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       run,
   input  wire logic [1:0] prescale,
   input  wire logic [7:0] period,
   output logic      [7:0] count,
   output logic      [1:0] phase,
   output logic            period_start
);

   typedef struct packed {
      logic [7:0] presc;
      logic [7:0] count;
      logic       start;
   } pwmcs_tmr_t;

   pwmcs_tmr_t s;
   pwmcs_tmr_t next_s;
   logic [2:0] shift;
   logic [7:0] limit;

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler and 8-bit period timer; period = (period+1) * 4 * prescale clocks
   always_comb begin
      shift        = pwmcs_pkg::presc_shift(prescale);
      limit        = 8'((pwmcs_pkg::PHASES << shift) - 9'h001);
      next_s       = s;
      next_s.start = 1'b0;
      if (!aresetn) begin
         next_s = '0;
      end else if (run) begin
         if (s.presc >= limit) begin
            next_s.presc = 8'h00;
            // the step after count equals period wraps and opens a period
            if (s.count == period) begin
               next_s.count = 8'h00;
               next_s.start = 1'b1;
            end else begin
               next_s.count = s.count + 8'h01;
            end
         end else begin
            next_s.presc = s.presc + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      s <= next_s;
   end

   // low two time-base bits: clock phase at 1:1, prescaler bits otherwise
   assign count        = s.count;
   assign phase        = 2'(s.presc >> shift);
   assign period_start = s.start;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   chk_timer_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (run && s.presc >= limit && s.count == period)
      |=> (s.count == 8'h00 && s.start))
      else $error("timer did not wrap after reaching period");

   chk_fast_phase: assert property (@(posedge aclk) disable iff (!aresetn)
      (run && prescale == 2'h0 && s.presc < 8'h03 && !s.start)
      |=> (phase == $past(phase) + 2'h1 || prescale != 2'h0))
      else $error("time base low bits do not follow clock phase at 1:1");

endmodule

// [dv/pwmcs_pin_model.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// pad behind the pin select: follows the block while driven, else floats
module pwmcs_pin_model (
   input  wire logic aclk,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      pad
);
   logic float_q;

   // an undriven pad wanders every cycle so a stale level never passes
   always_ff @(posedge aclk) begin
      float_q <= (float_q !== 1'b1);
   end

   // input mode leaves the pad to the outside world
   assign pad = pin_oe ? pin_o : float_q;
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module testbench;
   logic        aclk;
   logic        aresetn;
   logic [4:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [4:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        pin_o;
   logic        pin_oe;
   logic        pad;
   int          fails;
   int          n_tests;

   pwmcs_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pwm_pin_o(pin_o), .pwm_pin_oe(pin_oe));

   pwmcs_pin_model pad_model (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pad(pad));

   ////////////////////////////////////////////////////////////////////////////////
   // 50 mhz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparisons and verdict
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         fails++;
         $display("mismatch at %0t: %0d cycles, expected %0d", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite master: holds each channel until its own handshake edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic aw_on = 1'b1;
      logic w_on = 1'b1;
      logic b_on = 1'b1;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_on || w_on || b_on) begin
         @(posedge aclk);
         if (aw_on && awready) begin
            aw_on = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_on && wready) begin
            w_on = 1'b0;
            wvalid <= 1'b0;
         end
         if (b_on && bvalid) begin
            b_on = 1'b0;
            bready <= 1'b0;
            chk_val({6'h00, bresp}, {6'h00, pwmcs_pkg::RESP_OKAY});
         end
      end
      // one edge apart, so a following call never re-raises bready in this step
      @(posedge aclk);
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
      logic ar_on = 1'b1;
      logic r_on = 1'b1;
      d = 8'hxx;
      r = 2'hx;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (ar_on || r_on) begin
         @(posedge aclk);
         if (ar_on && arready) begin
            ar_on = 1'b0;
            arvalid <= 1'b0;
         end
         if (r_on && rvalid) begin
            r_on = 1'b0;
            rready <= 1'b0;
            d = rdata[7:0];
            r = rresp;
         end
      end
      // one edge apart, so a following call never re-raises rready in this step
      @(posedge aclk);
   endtask

   // read one register and compare data and response
   task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk_val(d, exp);
      chk_val({6'h00, r}, {6'h00, pwmcs_pkg::RESP_OKAY});
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // one full pulse on the pad, measured in active-level terms
   task automatic measure(input logic pol, input int hi, input int per);
      int i = 0;
      int h = 0;
      int p = 0;
      @(negedge aclk);
      while ((pad ^ pol) !== 1'b0 && i < 3000) begin
         @(negedge aclk);
         i++;
      end
      while ((pad ^ pol) !== 1'b1 && i < 3000) begin
         @(negedge aclk);
         i++;
      end
      while ((pad ^ pol) === 1'b1 && i < 3000) begin
         @(negedge aclk);
         h++;
         i++;
      end
      p = h;
      while ((pad ^ pol) === 1'b0 && i < 3000) begin
         @(negedge aclk);
         p++;
         i++;
      end
      chk_cnt(h, hi);
      chk_cnt(p, per);
      @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rdc(pwmcs_pkg::OFS_CONTROL, 8'h00);
      rdc(pwmcs_pkg::OFS_PIN, 8'h80);
      chk_val({7'h00, pin_oe}, 8'h00);
   endtask

   task automatic t_control();
      logic [7:0] d;
      logic [1:0] r;
      wr(pwmcs_pkg::OFS_CONTROL, 8'hff);
      rdc(pwmcs_pkg::OFS_CONTROL, 8'hb0);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h00);
      rdc(pwmcs_pkg::OFS_CONTROL, 8'h00);
      rd(5'h02, d, r);
      chk_val({6'h00, r}, {6'h00, pwmcs_pkg::RESP_SLVERR});
      chk_val(d, 8'h00);
   endtask

   task automatic t_duty();
      wr(pwmcs_pkg::OFS_DUTY_HI, 8'ha5);
      rdc(pwmcs_pkg::OFS_DUTY_HI, 8'ha5);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h90);
      do_reset();
      rdc(pwmcs_pkg::OFS_DUTY_HI, 8'ha5);
      rdc(pwmcs_pkg::OFS_CONTROL, 8'h00);
   endtask

   // ordered bring-up, duty 2 at period 0: two clocks high out of four
   task automatic t_bringup();
      logic [7:0] d;
      logic [1:0] r;
      int         i = 0;
      wr(pwmcs_pkg::OFS_PIN, 8'h80);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h00);
      wr(pwmcs_pkg::OFS_PERIOD, 8'h00);
      wr(pwmcs_pkg::OFS_DUTY_HI, 8'h00);
      wr(pwmcs_pkg::OFS_DUTY_LO, 8'h80);
      wr(pwmcs_pkg::OFS_FLAGS, 8'h01);
      wr(pwmcs_pkg::OFS_TCTL, 8'h80);
      d = 8'h00;
      while (d[pwmcs_pkg::FLAG_BIT] !== 1'b1 && i < 50) begin
         rd(pwmcs_pkg::OFS_FLAGS, d, r);
         i++;
      end
      chk_val({7'h00, d[pwmcs_pkg::FLAG_BIT]}, 8'h01);
      wr(pwmcs_pkg::OFS_PIN, 8'h01);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h80);
      chk_val({7'h00, pin_oe}, 8'h01);
      measure(1'b0, 2, 4);
   endtask

   task automatic t_rates();
      wr(pwmcs_pkg::OFS_DUTY_LO, 8'h00);
      wr(pwmcs_pkg::OFS_PERIOD, 8'h3f);
      wr(pwmcs_pkg::OFS_DUTY_HI, 8'h20);
      measure(1'b0, 128, 256);
      wr(pwmcs_pkg::OFS_PERIOD, 8'hff);
      wr(pwmcs_pkg::OFS_DUTY_HI, 8'h80);
      measure(1'b0, 512, 1024);
   endtask

   task automatic t_polarity();
      int bad = 0;
      wr(pwmcs_pkg::OFS_CONTROL, 8'h90);
      measure(1'b1, 512, 1024);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h10);
      repeat (1100) begin
         @(negedge aclk);
         if (pad !== 1'b1) bad++;
      end
      @(posedge aclk);
      chk_cnt(bad, 0);
      rdc(pwmcs_pkg::OFS_CONTROL, 8'h30);
   endtask

   // prescale 1:4 at period 0, duty 2: eight clocks high out of sixteen
   task automatic t_prescale();
      do_reset();
      wr(pwmcs_pkg::OFS_PERIOD, 8'h00);
      wr(pwmcs_pkg::OFS_DUTY_HI, 8'h00);
      wr(pwmcs_pkg::OFS_DUTY_LO, 8'h80);
      wr(pwmcs_pkg::OFS_PIN, 8'h01);
      wr(pwmcs_pkg::OFS_CONTROL, 8'h80);
      wr(pwmcs_pkg::OFS_TCTL, 8'h81);
      measure(1'b0, 8, 16);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      fails = 0;
      n_tests = 0;
      awaddr = 5'h00;
      awvalid = 1'b0;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 5'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      do_reset();
      t_reset();
      t_control();
      t_duty();
      t_bringup();
      t_rates();
      t_polarity();
      t_prescale();
      end_sim();
   end

   // watchdog well beyond the expected run of some six thousand cycles
   initial begin
      #(20000 * 20);
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
